// [common/acb_pkg.sv]
// shared constants, register map and types of the converter config bank
package acb_pkg;
  // ****************************************
  // datapath and timing
  // ****************************************
  localparam int SAMP_W = 14;
  localparam int LATENCY = 11;
  localparam int PED_W = 6;
  localparam int FRAC_W = 31;
  localparam int TAU_BASE = 20;
  localparam logic [3:0] TAU_MAX = 4'hB;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_US = 100;
  localparam int WAKE_CYC_DEF = WAKE_US * CLK_MHZ;
  // ****************************************
  // register map
  // ****************************************
  localparam int NREG = 16;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ADR_TUNE_A = 8'h06;
  localparam logic [7:0] ADR_FMT = 8'h29;
  localparam logic [7:0] ADR_DCEN = 8'h3D;
  localparam logic [7:0] ADR_DIGEN = 8'h44;
  localparam logic [7:0] ADR_PWR = 8'h45;
  localparam logic [7:0] ADR_TUNE_B = 8'hBA;
  localparam logic [7:0] ADR_PED_A = 8'hBF;
  localparam logic [7:0] ADR_PED_B = 8'hC1;
  localparam logic [7:0] ADR_LOOP = 8'hCF;
  localparam logic [7:0] ADR_TUNE_C = 8'hD5;
  localparam logic [7:0] ADR_TUNE_D = 8'hD9;
  localparam logic [7:0] ADR_TUNE_SB = 8'hDB;
  localparam logic [7:0] ADR_TUNE_E = 8'hDC;
  localparam logic [7:0] ADR_SLOW_M = 8'hEF;
  localparam logic [7:0] ADR_SWING = 8'hF1;
  localparam logic [7:0] ADR_SLOW_A = 8'hF2;
  localparam logic [7:0] ADR_TAB [NREG] = '{ADR_TUNE_A, ADR_FMT, ADR_DCEN, ADR_DIGEN, ADR_PWR,
    ADR_TUNE_B, ADR_PED_A, ADR_PED_B, ADR_LOOP, ADR_TUNE_C, ADR_TUNE_D, ADR_TUNE_SB,
    ADR_TUNE_E, ADR_SLOW_M, ADR_SWING, ADR_SLOW_A};
  localparam int I_TA = 0, I_FMT = 1, I_DCEN = 2, I_DIGEN = 3, I_PWR = 4, I_TB = 5;
  localparam int I_PED_A = 6, I_PED_B = 7, I_LOOP = 8, I_TC = 9, I_TD = 10, I_TSB = 11;
  localparam int I_TE = 12, I_SLOW_M = 13, I_SWING = 14, I_SLOW_A = 15;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_STRENGTH = 5;
  localparam int B_PDN = 2;
  localparam int B_DCEN = 5;
  localparam int B_DIGEN = 0;
  localparam int B_FREEZE = 7;
  localparam int TAU_LSB = 2;
  localparam int PED_LSB = 2;
  localparam int FMT_LSB = 3;
  localparam logic [1:0] FMT_OB = 2'b11;
  localparam logic [1:0] SWING_ON = 2'b11;
  localparam logic [1:0] SWING_OFF = 2'b00;
  localparam int B_SLOW_B = 0;
  localparam int B_SLOW_M = 4;
  localparam int B_SLOW_A = 3;
  // ****************************************
  // host command registers on the bus
  // ****************************************
  localparam logic [31:0] HA_CMD = 32'h0000_0000;
  localparam logic [31:0] HA_STAT = 32'h0000_0004;
  localparam int C_ADDR_LSB = 8;
  localparam int C_WR = 16;
  localparam int S_BUSY = 8;
  localparam int S_REF = 9;
  typedef enum logic [1:0] {HS_IDLE = 2'b01, HS_WAIT = 2'b10} acb_hst_t;
  // writable bits per address, all others read zero
  function automatic logic [7:0] reg_wmask(input logic [7:0] a);
    case (a)
      ADR_TUNE_A: reg_wmask = 8'h06;
      ADR_FMT: reg_wmask = 8'h18;
      ADR_DCEN: reg_wmask = 8'h20;
      ADR_DIGEN: reg_wmask = 8'h01;
      ADR_PWR: reg_wmask = 8'h24;
      ADR_TUNE_B: reg_wmask = 8'h08;
      ADR_PED_A: reg_wmask = 8'hFC;
      ADR_PED_B: reg_wmask = 8'hFC;
      ADR_LOOP: reg_wmask = 8'hBC;
      ADR_TUNE_C: reg_wmask = 8'h20;
      ADR_TUNE_D: reg_wmask = 8'h22;
      ADR_TUNE_SB: reg_wmask = 8'hE1;
      ADR_TUNE_E: reg_wmask = 8'h22;
      ADR_SLOW_M: reg_wmask = 8'h10;
      ADR_SWING: reg_wmask = 8'h03;
      ADR_SLOW_A: reg_wmask = 8'h08;
      default: reg_wmask = 8'h00;
    endcase
  endfunction
endpackage

// [common/acb_link_if.sv]
// register programming link between host controller and converter bank
`timescale 1ns/10ps
interface acb_link_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport dev (input req, input wr, input addr, input wdata, output rdata, output ack);
  modport host (output req, output wr, output addr, output wdata, input rdata, input ack);
endinterface

// [hdl/acb_dly.sv]
// fixed-depth delay line for one sample word
`timescale 1ns/10ps
module acb_dly #(
  parameter int W = 14,
  parameter int D = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stg_ff [D];

  if (D < 1) begin : g_bad
    $error("acb_dly: depth below one");
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      for (int i = 0; i < D; i++)
        stg_ff[i] <= '0;
    else
    begin
      stg_ff[0] <= din;
      for (int i = 1; i < D; i++)
        stg_ff[i] <= stg_ff[i-1];
    end
  end

  assign dout = stg_ff[D-1];
endmodule

// [hdl/acb_dev.sv]
// converter end: configuration bank, dc loop and output stage
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module acb_dev import acb_pkg::*; #(
  parameter int WAKE_CYCLES = WAKE_CYC_DEF,
  parameter int DW = SAMP_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register link
  acb_link_if.dev lnk,
  // converter samples
  input wire logic [DW-1:0] samp_a,
  input wire logic [DW-1:0] samp_b,
  // output data
  output logic [DW-1:0] dout_a,
  output logic [DW-1:0] dout_b,
  output logic dout_vld,
  // analog controls
  output logic drive_double,
  output logic full_chip_powerdown,
  output logic chan_a_slow_rate,
  output logic chan_b_slow_rate,
  output logic swing_apply,
  output logic [11:1] perf_tune_bits
);
  localparam int CW = $clog2(WAKE_CYCLES + 1);
  localparam int EW = DW + FRAC_W;

  if (DW != SAMP_W || WAKE_CYCLES < 1) begin : g_bad
    $error("acb_dev: unsupported width or wake count");
  end

  logic [7:0] regs_ff [NREG];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic ack_ff;
  logic [CW-1:0] wake_ff;
  logic vld_ff;
  logic drv_ff;
  logic pdn_ff;
  logic slow_a_ff;
  logic slow_b_ff;
  logic swing_ff;
  logic [11:1] tune_ff;
  logic [DW-1:0] samp_ff [2];
  logic [DW-1:0] dly [2];
  logic [DW-1:0] dout_ff [2];
  logic signed [EW-1:0] est_ff [2];
  logic dig_on;
  logic loop_on;
  logic freeze;
  logic fmt_ob;
  logic [3:0] tau_eff;
  logic [5:0] shift;

  // ****************************************
  // register bank
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      for (int i = 0; i < NREG; i++)
        regs_ff[i] <= REG_RST;
    else if (lnk.req && lnk.wr)
      for (int i = 0; i < NREG; i++)
        if (lnk.addr == ADR_TAB[i])
          regs_ff[i] <= lnk.wdata & reg_wmask(lnk.addr);
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < NREG; i++)
      if (lnk.addr == ADR_TAB[i])
        nxt_rdata = regs_ff[i];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= (lnk.req && !lnk.wr) ? nxt_rdata : 8'h00;
      ack_ff <= lnk.req;
    end
  end

  assign lnk.rdata = rdata_ff;
  assign lnk.ack = ack_ff;

  // ****************************************
  // static controls
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      drv_ff <= 1'b0;
      pdn_ff <= 1'b0;
      slow_a_ff <= 1'b0;
      slow_b_ff <= 1'b0;
      swing_ff <= 1'b0;
      tune_ff <= '0;
    end
    else
    begin
      drv_ff <= regs_ff[I_PWR][B_STRENGTH];
      pdn_ff <= regs_ff[I_PWR][B_PDN];
      slow_a_ff <= regs_ff[I_SLOW_M][B_SLOW_M] && regs_ff[I_SLOW_A][B_SLOW_A];
      slow_b_ff <= regs_ff[I_SLOW_M][B_SLOW_M] && regs_ff[I_TSB][B_SLOW_B];
      swing_ff <= regs_ff[I_SWING][1:0] == SWING_ON;
      tune_ff <= {regs_ff[I_TE][5], regs_ff[I_TE][1], regs_ff[I_TSB][7:5], regs_ff[I_TD][5],
        regs_ff[I_TD][1], regs_ff[I_TC][5], regs_ff[I_TB][3], regs_ff[I_TA][2:1]};
    end
  end

  // ****************************************
  // power-down and wake-up
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wake_ff <= '0;
      vld_ff <= 1'b0;
    end
    else
    begin
      if (regs_ff[I_PWR][B_PDN])
        wake_ff <= CW'(WAKE_CYCLES);
      else if (wake_ff != '0)
        wake_ff <= wake_ff - 1'b1;
      vld_ff <= !regs_ff[I_PWR][B_PDN] && wake_ff == '0;
    end
  end

  // ****************************************
  // dc loop controls
  // ****************************************
  assign dig_on = regs_ff[I_DIGEN][B_DIGEN];
  assign loop_on = dig_on && regs_ff[I_DCEN][B_DCEN];
  assign freeze = regs_ff[I_LOOP][B_FREEZE];
  assign fmt_ob = regs_ff[I_FMT][FMT_LSB+1:FMT_LSB] == FMT_OB;
  // reserved codes fall back to the slowest constant
  assign tau_eff = (regs_ff[I_LOOP][TAU_LSB+3:TAU_LSB] > TAU_MAX) ?
    TAU_MAX : regs_ff[I_LOOP][TAU_LSB+3:TAU_LSB];
  assign shift = 6'(TAU_BASE) + {2'b00, tau_eff};

  // ****************************************
  // per-channel datapath
  // ****************************************
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    localparam int IP = (c == 0) ? I_PED_A : I_PED_B;
    logic signed [DW-1:0] xc;
    logic signed [DW-1:0] est_int;
    logic signed [PED_W-1:0] ped;
    logic signed [EW:0] err;
    logic signed [DW+1:0] sum;
    logic [DW-1:0] sat;
    logic [DW-1:0] res;

    always_ff @(posedge mclk)
    begin
      if (!rst_b)
        samp_ff[c] <= '0;
      else
        samp_ff[c] <= (c == 0) ? samp_a : samp_b;
    end

    acb_dly #(.W(DW), .D(LATENCY - 1)) u_dly (
      .mclk(mclk),
      .rst_b(rst_b),
      .din(samp_ff[c]),
      .dout(dly[c])
    );

    // converter code is offset binary; work around midcode as zero
    assign xc = {~dly[c][DW-1], dly[c][DW-2:0]};
    assign err = {xc[DW-1], xc, FRAC_W'(0)} - {est_ff[c][EW-1], est_ff[c]};
    assign est_int = est_ff[c][EW-1:FRAC_W];
    assign ped = regs_ff[IP][PED_LSB+PED_W-1:PED_LSB];

    always_ff @(posedge mclk)
    begin
      if (!rst_b)
        est_ff[c] <= '0;
      else if (!loop_on)
        est_ff[c] <= '0;
      else if (!freeze)
        est_ff[c] <= est_ff[c] + EW'(err >>> shift);
    end

    assign sum = {{2{xc[DW-1]}}, xc} - {{2{est_int[DW-1]}}, est_int}
      + {{(DW+2-PED_W){ped[PED_W-1]}}, ped};
    assign sat = (sum[DW+1:DW-1] == 3'b000 || sum[DW+1:DW-1] == 3'b111) ?
      sum[DW-1:0] : {sum[DW+1], {(DW-1){~sum[DW+1]}}};
    assign res = loop_on ? sat : xc;

    always_ff @(posedge mclk)
    begin
      if (!rst_b)
        dout_ff[c] <= '0;
      else if (!vld_ff)
        dout_ff[c] <= '0;
      else
        dout_ff[c] <= fmt_ob ? {~res[DW-1], res[DW-2:0]} : res;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dout_a = dout_ff[0];
  assign dout_b = dout_ff[1];
  assign dout_vld = vld_ff;
  assign drive_double = drv_ff;
  assign full_chip_powerdown = pdn_ff;
  assign chan_a_slow_rate = slow_a_ff;
  assign chan_b_slow_rate = slow_b_ff;
  assign swing_apply = swing_ff;
  assign perf_tune_bits = tune_ff;
endmodule

// [hdl/acb_host.sv]
// host end: AHB-Lite command registers driving the programming link
`timescale 1ns/10ps
module acb_host import acb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // programming link
  acb_link_if.host lnk
);
  acb_hst_t st_ff;
  logic wpend_ff;
  logic [31:0] waddr_ff;
  logic [31:0] hrdata_ff;
  logic req_ff;
  logic wr_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rd_ff;
  logic ref_ff;
  logic sh_slow_ff;
  logic sh_dc_ff;
  logic sh_dig_ff;
  logic cmd_wr;
  logic [7:0] c_addr;
  logic [7:0] c_data;
  logic refuse;

  // ****************************************
  // bus slave, zero wait states
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wpend_ff <= 1'b0;
      waddr_ff <= '0;
      hrdata_ff <= '0;
    end
    else
    begin
      wpend_ff <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready)
        waddr_ff <= haddr;
      if (hsel && htrans[1] && hready && !hwrite)
        hrdata_ff <= (haddr == HA_STAT) ? {22'h0, ref_ff, st_ff == HS_WAIT, rd_ff} : 32'h0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // ****************************************
  // command checks
  // ****************************************
  assign cmd_wr = wpend_ff && waddr_ff == HA_CMD;
  assign c_addr = hwdata[C_ADDR_LSB+7:C_ADDR_LSB];
  assign c_data = hwdata[7:0] & reg_wmask(c_addr);
  always_comb
  begin
    refuse = 1'b0;
    if (hwdata[C_WR])
    begin
      if (!sh_slow_ff && (c_addr == ADR_SLOW_A || (c_addr == ADR_TUNE_SB && c_data[B_SLOW_B])))
        refuse = 1'b1;
      if (!sh_dc_ff && c_addr == ADR_LOOP)
        refuse = 1'b1;
      if (!sh_dig_ff && (c_addr == ADR_LOOP || c_addr == ADR_PED_A || c_addr == ADR_PED_B))
        refuse = 1'b1;
      if (c_addr == ADR_SWING && c_data[1:0] != SWING_ON && c_data[1:0] != SWING_OFF)
        refuse = 1'b1;
    end
  end

  // ****************************************
  // link sequencer
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_ff <= HS_IDLE;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rd_ff <= 8'h00;
    end
    else
    begin
      req_ff <= 1'b0;
      case (st_ff)
        HS_IDLE:
          if (cmd_wr && !refuse)
          begin
            req_ff <= 1'b1;
            wr_ff <= hwdata[C_WR];
            addr_ff <= c_addr;
            wdata_ff <= hwdata[C_WR] ? c_data : 8'h00;
            st_ff <= HS_WAIT;
          end
        HS_WAIT:
          if (lnk.ack)
          begin
            rd_ff <= lnk.rdata;
            st_ff <= HS_IDLE;
          end
        default:
          st_ff <= HS_IDLE;
      endcase
    end
  end

  // shadows of the enables this host has written
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sh_slow_ff <= 1'b0;
      sh_dc_ff <= 1'b0;
      sh_dig_ff <= 1'b0;
    end
    else if (st_ff == HS_IDLE && cmd_wr && !refuse && hwdata[C_WR])
    begin
      if (c_addr == ADR_SLOW_M)
        sh_slow_ff <= c_data[B_SLOW_M];
      if (c_addr == ADR_DCEN)
        sh_dc_ff <= c_data[B_DCEN];
      if (c_addr == ADR_DIGEN)
        sh_dig_ff <= c_data[B_DIGEN];
    end
  end

  // refused flag: set wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      ref_ff <= 1'b0;
    else if (cmd_wr && (refuse || st_ff != HS_IDLE))
      ref_ff <= 1'b1;
    else if (wpend_ff && waddr_ff == HA_STAT && hwdata[S_REF])
      ref_ff <= 1'b0;
  end

  assign lnk.req = req_ff;
  assign lnk.wr = wr_ff;
  assign lnk.addr = addr_ff;
  assign lnk.wdata = wdata_ff;
endmodule

// [bench/acb_link_assertions.sv]
// concurrent checks on the programming link and the converter control outputs
`timescale 1ns/10ps
module acb_link_assertions import acb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // programming link
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  // converter outputs
  input wire logic drive_double,
  input wire logic full_chip_powerdown,
  input wire logic chan_a_slow_rate,
  input wire logic chan_b_slow_rate,
  input wire logic swing_apply,
  input wire logic dout_vld,
  input wire logic [SAMP_W-1:0] dout_a,
  input wire logic [SAMP_W-1:0] dout_b
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ****************************************
  // link handshake
  // ****************************************
  property p_ack_after_req;
    req |=> ack;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("no ack one cycle after request");
  property p_ack_has_cause;
    ack |-> $past(req);
  endproperty
  a_ack_has_cause: assert property (p_ack_has_cause) else $error("ack without a request");
  property p_req_spacing;
    req |=> !req [*2];
  endproperty
  a_req_spacing: assert property (p_req_spacing) else $error("requests too close together");
  property p_rdata_idle;
    !ack |-> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack cycle");
  // ****************************************
  // control outputs follow register writes
  // ****************************************
  property p_strength;
    logic v;
    (req && wr && addr == ADR_PWR, v = wdata[B_STRENGTH]) |-> ##2 drive_double == v;
  endproperty
  a_strength: assert property (p_strength) else $error("drive strength not as written");
  property p_pdn;
    logic v;
    (req && wr && addr == ADR_PWR, v = wdata[B_PDN]) |-> ##2 full_chip_powerdown == v;
  endproperty
  a_pdn: assert property (p_pdn) else $error("powerdown not as written");
  property p_pdn_out;
    full_chip_powerdown && $past(full_chip_powerdown) |-> !dout_vld && dout_a == '0 && dout_b == '0;
  endproperty
  a_pdn_out: assert property (p_pdn_out) else $error("outputs active in powerdown");
  property p_wake;
    $fell(full_chip_powerdown) |-> !dout_vld [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("data valid too soon after wake");
  property p_swing;
    logic v;
    (req && wr && addr == ADR_SWING, v = (wdata[1:0] == SWING_ON)) |-> ##2 swing_apply == v;
  endproperty
  a_swing: assert property (p_swing) else $error("swing apply not as written");
  property p_slow_gate;
    req && wr && addr == ADR_SLOW_M && !wdata[B_SLOW_M] |-> ##2 !chan_a_slow_rate && !chan_b_slow_rate;
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("slow mode on without master");
  // ****************************************
  // scenario coverage
  // ****************************************
  c_read: cover property (ack && !wr);
  c_wake: cover property ($fell(full_chip_powerdown));
  c_swing: cover property (swing_apply);
endmodule

// [bench/tb_top.sv]
// self-checking bench for the host and converter ends of the programming link
`timescale 1ns/10ps
module tb_top import acb_pkg::*;;
  localparam int WAKE = 20;
  localparam int CYC_MAX = 30000;
  // writable bits of each register, in map order
  localparam logic [7:0] MASK [NREG] = '{8'h06, 8'h18, 8'h20, 8'h01, 8'h24, 8'h08, 8'hFC, 8'hFC, 8'hBC,
    8'h20, 8'h22, 8'hE1, 8'h22, 8'h10, 8'h03, 8'h08};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [SAMP_W-1:0] samp_a = 14'h2000;
  logic [SAMP_W-1:0] samp_b = 14'h2000;
  logic [SAMP_W-1:0] dout_a;
  logic [SAMP_W-1:0] dout_b;
  logic dout_vld;
  logic drive_double;
  logic full_chip_powerdown;
  logic chan_a_slow_rate;
  logic chan_b_slow_rate;
  logic swing_apply;
  logic [11:1] perf_tune_bits;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pd_cnt = 0;
  acb_link_if lnk();
  acb_host u_acb_host (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .lnk(lnk));
  acb_dev #(.WAKE_CYCLES(WAKE)) u_acb_dev (.mclk(mclk), .rst_b(rst_b), .lnk(lnk), .samp_a(samp_a),
    .samp_b(samp_b), .dout_a(dout_a), .dout_b(dout_b), .dout_vld(dout_vld), .drive_double(drive_double),
    .full_chip_powerdown(full_chip_powerdown), .chan_a_slow_rate(chan_a_slow_rate),
    .chan_b_slow_rate(chan_b_slow_rate), .swing_apply(swing_apply), .perf_tune_bits(perf_tune_bits));
  acb_link_assertions u_acb_link_assertions (.mclk(mclk), .rst_b(rst_b), .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .drive_double(drive_double),
    .full_chip_powerdown(full_chip_powerdown), .chan_a_slow_rate(chan_a_slow_rate),
    .chan_b_slow_rate(chan_b_slow_rate), .swing_apply(swing_apply), .dout_vld(dout_vld), .dout_a(dout_a),
    .dout_b(dout_b));
  always #5 mclk = ~mclk;
  // ****************************************
  // cycle counters and hang guard
  // ****************************************
  always @(posedge mclk)
  begin
    pd_cnt <= full_chip_powerdown ? 0 : pd_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == CYC_MAX)
    begin
      failures++;
      complete_run;
    end
  end
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  // one command over the link, then poll until the host is idle
  task automatic link_cmd(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] st);
    logic [31:0] rd;
    int n;
    ahb(1'b1, HA_CMD, {15'h0, w, a, d}, rd);
    n = 0;
    st = 32'h0000_0100;
    while (st[S_BUSY] !== 1'b0 && n < 50)
    begin
      ahb(1'b0, HA_STAT, 32'h0, st);
      n++;
    end
    chk("busy cleared", n < 50, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] st;
    link_cmd(1'b0, a, 8'h00, st);
    chk($sformatf("reg %h", a), st[7:0], e);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] st;
    chk("hresp", hresp, 1'b0);
    chk("hready", hreadyout, 1'b1);
    chk("drive", drive_double, 1'b0);
    chk("powerdown", full_chip_powerdown, 1'b0);
    chk("tune", perf_tune_bits, 11'h000);
    chk("swing", swing_apply, 1'b0);
    for (int i = 0; i < NREG; i++) rd_chk(ADR_TAB[i], 8'h00);
    ahb(1'b0, 32'h0000_0008, 32'h0, st);
    chk("bus hole", st, 32'h0);
  endtask
  task automatic t_regs;
    logic [31:0] st;
    link_cmd(1'b1, ADR_DIGEN, 8'h01, st);
    link_cmd(1'b1, ADR_DCEN, 8'h20, st);
    link_cmd(1'b1, ADR_SLOW_M, 8'h10, st);
    link_cmd(1'b1, ADR_TUNE_SB, 8'h20, st);
    chk("tune order", perf_tune_bits, 11'h040);
    for (int i = 0; i < NREG; i++) link_cmd(1'b1, ADR_TAB[i], 8'hFF, st);
    for (int i = 0; i < NREG; i++) rd_chk(ADR_TAB[i], MASK[i]);
    rd_chk(8'h10, 8'h00);
    chk("tune", perf_tune_bits, 11'h7FF);
    chk("drive", drive_double, 1'b1);
    chk("powerdown", full_chip_powerdown, 1'b1);
    chk("swing", swing_apply, 1'b1);
    chk("slow a", chan_a_slow_rate, 1'b1);
    chk("slow b", chan_b_slow_rate, 1'b1);
    chk("valid", dout_vld, 1'b0);
    chk("dout a", dout_a, 14'h0000);
    chk("dout b", dout_b, 14'h0000);
  endtask
  task automatic t_pdn;
    logic [31:0] st;
    link_cmd(1'b1, ADR_PWR, 8'h20, st);
    chk("valid early", dout_vld, 1'b0);
    for (int n = 0; n < 100 && dout_vld !== 1'b1; n++) @(posedge mclk);
    chk("wake", pd_cnt >= WAKE && pd_cnt <= WAKE + 4, 1'b1);
    chk("drive", drive_double, 1'b1);
  endtask
  task automatic t_slow;
    logic [31:0] st;
    link_cmd(1'b1, ADR_SLOW_A, 8'h00, st);
    chk("slow a", chan_a_slow_rate, 1'b0);
    chk("slow b", chan_b_slow_rate, 1'b1);
    link_cmd(1'b1, ADR_SLOW_M, 8'h00, st);
    chk("slow b", chan_b_slow_rate, 1'b0);
  endtask
  task automatic t_refuse;
    logic [7:0] ra [5] = '{ADR_SWING, ADR_SWING, ADR_SLOW_A, ADR_TUNE_SB, ADR_LOOP};
    logic [7:0] wd [5] = '{8'h01, 8'h02, 8'h08, 8'h01, 8'h80};
    logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h00, 8'hE1, 8'hBC};
    logic [31:0] st;
    link_cmd(1'b1, ADR_SWING, 8'h00, st);
    chk("swing", swing_apply, 1'b0);
    link_cmd(1'b1, ADR_DCEN, 8'h00, st);
    for (int i = 0; i < 5; i++)
    begin
      link_cmd(1'b1, ra[i], wd[i], st);
      chk("refused", st[S_REF], 1'b1);
      ahb(1'b1, HA_STAT, 32'h0000_0200, st);
      rd_chk(ra[i], ex[i]);
    end
    chk("swing", swing_apply, 1'b0);
    chk("slow a", chan_a_slow_rate, 1'b0);
  endtask
  task automatic t_lat;
    logic [31:0] st;
    int k;
    link_cmd(1'b1, ADR_DIGEN, 8'h00, st);
    samp_a <= 14'h1234;
    samp_b <= 14'h0ABC;
    for (k = 1; k <= 30; k++)
    begin
      @(posedge mclk);
      samp_a <= 14'h2000;
      samp_b <= 14'h2000;
      #1;
      if (dout_a === 14'h1234) break;
    end
    chk("latency", k, 12);
    chk("dout b", dout_b, 14'h0ABC);
    @(posedge mclk);
  endtask
  task automatic t_ped;
    logic [31:0] st;
    link_cmd(1'b1, ADR_DIGEN, 8'h01, st);
    link_cmd(1'b1, ADR_FMT, 8'h00, st);
    link_cmd(1'b1, ADR_DCEN, 8'h20, st);
    link_cmd(1'b1, ADR_LOOP, 8'h80, st);
    link_cmd(1'b1, ADR_PED_A, 8'h7C, st);
    link_cmd(1'b1, ADR_PED_B, 8'h80, st);
    repeat (16) @(posedge mclk);
    chk("ped a twos", dout_a, 14'h001F);
    chk("ped b twos", dout_b, 14'h3FE0);
    link_cmd(1'b1, ADR_FMT, 8'h18, st);
    repeat (16) @(posedge mclk);
    chk("ped a bin", dout_a, 14'h201F);
    chk("ped b bin", dout_b, 14'h1FE0);
    link_cmd(1'b1, ADR_PED_A, 8'hFC, st);
    samp_a <= 14'h2100;
    repeat (10000) @(posedge mclk);
    chk("frozen", dout_a, 14'h20FF);
    link_cmd(1'b1, ADR_LOOP, 8'h00, st);
    repeat (10000) @(posedge mclk);
    chk("tracking", dout_a < 14'h20FF, 1'b1);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_regs();
    t_pdn();
    t_slow();
    t_refuse();
    t_lat();
    t_ped();
    complete_run;
  end
endmodule
